// >>> rtl/asop_host.sv
// Controller end: starts conversions and reads words in either port mode.
`timescale 1ns/1ps
module asop_host #(
  parameter int unsigned EXT_HALF = asop_pkg::EXT_HALF_CYC
) (
  input wire logic clock_i,  // Controller clock.
  input wire logic sys_rst_i,  // Asynchronous reset, active high.
  input wire logic self_mode_i,  // Strap: 1 self-clocked, 0 external clock.
  input wire logic polarity_i,  // Strap: 1 two's complement, 0 offset binary.
  input wire logic conversion_start_n_req_i,  // Strobe: start one conversion.
  input wire logic conversion_start_n_cont_i,  // Level: convert continuously.
  input wire logic cs_hold_i,  // Level: keep select low between words.
  output logic [15:0] word_o,  // Last word read.
  output logic word_valid_o,  // Strobe: word_o updated.
  output logic reading_o,  // External-clock read in progress.
  asop_if.host lnk  // Pins toward the converter.
);

  if (EXT_HALF < 8)
  begin : g_bad_half
    $error("asop_host needs EXT_HALF of at least 8");
  end

  localparam logic [7:0] HALF_LAST = 8'(EXT_HALF - 1);
  localparam logic [4:0] RISES_LAST = 5'(asop_pkg::SCLK_RISES);
  localparam logic [4:0] RX_LAST = 5'(asop_pkg::WORD_BITS);
  localparam logic [5:0] CONVERSION_START_N_LOW = 6'(asop_pkg::HOST_CONVERSION_START_N_LOW_CYC);

  // ---------------------------------------------------------------
  // Self-clocked receive, on the converter's shift clock
  // ---------------------------------------------------------------
  logic [4:0] rx_cnt_q;
  logic [15:0] rx_sr_q;
  logic [15:0] rx_word_q;
  logic rx_tgl_q;

  // The first edge only presents the MSB; edges 2 to 17 each capture one bit.
  always_ff @(posedge lnk.sclk or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rx_cnt_q <= 5'h00;
      rx_sr_q <= 16'h0000;
      rx_word_q <= 16'h0000;
      rx_tgl_q <= 1'b0;
    end
    else if (rx_cnt_q == RX_LAST)
    begin
      rx_word_q <= {rx_sr_q[14:0], lnk.sdo_line};
      rx_tgl_q <= !rx_tgl_q;
      rx_cnt_q <= 5'h00;
    end
    else
    begin
      if (rx_cnt_q != 5'h00)
        rx_sr_q <= {rx_sr_q[14:0], lnk.sdo_line};
      rx_cnt_q <= rx_cnt_q + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // Synchronisers into the controller clock
  // ---------------------------------------------------------------
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [2:0] tgl_q;
  logic rdy_prev_q;

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      meta_q <= asop_pkg::HOST_SYNC_RST;
      sync_q <= asop_pkg::HOST_SYNC_RST;
      tgl_q <= 3'h0;
      rdy_prev_q <= 1'b1;
    end
    else
    begin
      meta_q <= {lnk.rdy_n, lnk.sdo_line};
      sync_q <= meta_q;
      tgl_q <= {tgl_q[1:0], rx_tgl_q};
      rdy_prev_q <= sync_q[1];
    end
  end

  // ---------------------------------------------------------------
  // External-clock read sequencer
  // ---------------------------------------------------------------
  asop_pkg::asop_host_state_t state_q;
  logic [7:0] div_q;
  logic [4:0] rises_q;
  logic [15:0] sr_q;
  logic sclk_q;
  logic rdy_fall;
  logic half;

  assign rdy_fall = rdy_prev_q && !sync_q[1];
  assign half = (div_q == HALF_LAST);

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= asop_pkg::ASOP_H_IDLE;
      div_q <= 8'h00;
      rises_q <= 5'h00;
      sr_q <= 16'h0000;
      sclk_q <= 1'b0;
    end
    else
    begin
      div_q <= half ? 8'h00 : div_q + 8'h01;
      unique case (state_q)
        asop_pkg::ASOP_H_IDLE:
        begin
          div_q <= 8'h00;
          rises_q <= 5'h00;
          if (!self_mode_i && rdy_fall)
            state_q <= asop_pkg::ASOP_H_SETUP;
        end
        asop_pkg::ASOP_H_SETUP, asop_pkg::ASOP_H_LOW:
        begin
          if (half)
          begin
            sclk_q <= 1'b1;
            rises_q <= rises_q + 5'h01;
            if (rises_q != 5'h00)
              sr_q <= {sr_q[14:0], sync_q[0]};
            state_q <= asop_pkg::ASOP_H_HIGH;
          end
        end
        asop_pkg::ASOP_H_HIGH:
        begin
          if (half)
          begin
            sclk_q <= 1'b0;
            state_q <= (rises_q == RISES_LAST) ? asop_pkg::ASOP_H_END : asop_pkg::ASOP_H_LOW;
          end
        end
        asop_pkg::ASOP_H_END:
        begin
          state_q <= asop_pkg::ASOP_H_IDLE;
        end
        default:
        begin
          state_q <= asop_pkg::ASOP_H_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Results, select, strobes and start
  // ---------------------------------------------------------------
  logic cs_n_q;
  logic sclk_oe_q;
  logic conversion_start_n_n_q;
  logic [5:0] conversion_start_n_cnt_q;

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      word_o <= 16'h0000;
      word_valid_o <= 1'b0;
      reading_o <= 1'b0;
      cs_n_q <= 1'b1;
      sclk_oe_q <= 1'b0;
    end
    else
    begin
      word_valid_o <= 1'b0;
      if (state_q == asop_pkg::ASOP_H_END)
      begin
        word_o <= sr_q;
        word_valid_o <= 1'b1;
      end
      else if (self_mode_i && (tgl_q[2] != tgl_q[1]))
      begin
        word_o <= rx_word_q;
        word_valid_o <= 1'b1;
      end
      reading_o <= (state_q != asop_pkg::ASOP_H_IDLE) && (state_q != asop_pkg::ASOP_H_END);
      cs_n_q <= !(self_mode_i || cs_hold_i ||
                  ((state_q != asop_pkg::ASOP_H_IDLE) && (state_q != asop_pkg::ASOP_H_END)));
      sclk_oe_q <= !self_mode_i;
    end
  end

  // A single start goes high long before the conversion ends, and only when idle.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      conversion_start_n_n_q <= 1'b1;
      conversion_start_n_cnt_q <= 6'h00;
    end
    else if (conversion_start_n_cont_i)
    begin
      conversion_start_n_n_q <= 1'b0;
      conversion_start_n_cnt_q <= 6'h00;
    end
    else if (conversion_start_n_cnt_q != 6'h00)
    begin
      conversion_start_n_cnt_q <= conversion_start_n_cnt_q - 6'h01;
      conversion_start_n_n_q <= (conversion_start_n_cnt_q == 6'h01);
    end
    else if (conversion_start_n_req_i && (state_q == asop_pkg::ASOP_H_IDLE) && sync_q[1])
    begin
      conversion_start_n_n_q <= 1'b0;
      conversion_start_n_cnt_q <= CONVERSION_START_N_LOW;
    end
    else
    begin
      conversion_start_n_n_q <= 1'b1;
    end
  end

  assign lnk.cs_n = cs_n_q;
  assign lnk.conversion_start_n_n = conversion_start_n_n_q;
  assign lnk.sclk_host = sclk_q;
  assign lnk.sclk_host_oe = sclk_oe_q;
  assign lnk.mode = self_mode_i;
  assign lnk.pol = polarity_i;

endmodule : asop_host

// >>> rtl/asop_pkg.sv
// Shared constants, state encodings and coding function of the ADC serial output port.
package asop_pkg;

  // ---------------------------------------------------------------
  // Word and timing constants
  // ---------------------------------------------------------------
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned SCLK_RISES = WORD_BITS + 1;
  localparam int unsigned CONVERSION_START_N_CYCLES = 80;
  localparam int unsigned RDY_EARLY_CYC = 2;
  localparam int unsigned CONVERSION_START_N_HIGH_MIN_CYC = 20;
  localparam int unsigned HOST_CONVERSION_START_N_LOW_CYC = 8;
  localparam int unsigned SELF_HALF_CYC = 2;
  localparam int unsigned EXT_HALF_CYC = 8;

  // ---------------------------------------------------------------
  // Output codes and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] CODE_POS_MAX = 16'h7FFF;
  localparam logic [15:0] CODE_NEG_MIN = 16'h8000;
  localparam logic signed [17:0] LEVEL_POS_MAX = 18'sh07FFF;
  localparam logic signed [17:0] LEVEL_NEG_MIN = -18'sh08000;
  localparam logic [4:0] DEV_SYNC_RST = 5'h0C;
  localparam logic [1:0] HOST_SYNC_RST = 2'h2;

  typedef enum logic [2:0] {
    ASOP_H_IDLE = 3'b000,
    ASOP_H_SETUP = 3'b001,
    ASOP_H_HIGH = 3'b010,
    ASOP_H_LOW = 3'b011,
    ASOP_H_END = 3'b100
  } asop_host_state_t;

  // Clamp a level to 16 bits, then pick two's complement or offset binary.
  function automatic logic [15:0] asop_encode(input logic signed [17:0] level,
                                              input logic bipolar);
    logic [15:0] code;
    code = 16'h0000;
    if (level > LEVEL_POS_MAX)
      code = CODE_POS_MAX;
    else if (level < LEVEL_NEG_MIN)
      code = CODE_NEG_MIN;
    else
      code = level[15:0];
    // Offset binary is two's complement with the sign bit inverted.
    asop_encode = bipolar ? code : {~code[15], code[14:0]};
  endfunction : asop_encode

endpackage : asop_pkg

// >>> rtl/asop_if.sv
// Pin-level carrier joining the converter end and the controller end.
`timescale 1ns/1ps
interface asop_if;

  // ---------------------------------------------------------------
  // Pin signals and their resolved levels
  // ---------------------------------------------------------------
  logic sclk_dev;
  logic sclk_dev_oe;
  logic sclk_host;
  logic sclk_host_oe;
  logic sclk;
  logic serial_data_output;
  logic sdo_oe;
  logic sdo_line;
  logic cs_n;
  logic rdy_n;
  logic conversion_start_n_n;
  logic mode;
  logic pol;

  // Undriven pins settle low, as with the board pull-downs.
  assign sclk = sclk_dev_oe ? sclk_dev : (sclk_host_oe ? sclk_host : 1'b0);
  assign sdo_line = sdo_oe ? serial_data_output : 1'b0;

  modport dev (input sclk, input cs_n, input conversion_start_n_n, input mode, input pol,
               output sclk_dev, output sclk_dev_oe, output serial_data_output, output sdo_oe,
               output rdy_n);
  modport host (input sclk, input sdo_line, input rdy_n,
                output sclk_host, output sclk_host_oe, output cs_n, output conversion_start_n_n,
                output mode, output pol);

endinterface : asop_if

// >>> rtl/asop_shifter.sv
// Output shift register of the converter end, most significant bit first.
`timescale 1ns/1ps
module asop_shifter #(
  parameter int unsigned WIDTH = asop_pkg::WORD_BITS
) (
  input wire logic clock_i,  // Master clock.
  input wire logic sys_rst_i,  // Asynchronous reset, active high.
  input wire logic load_i,  // Load request for a finished word.
  input wire logic [WIDTH-1:0] word_i,  // Word to load.
  input wire logic shift_i,  // Present the next bit.
  output logic bit_o,  // Bit on the data pin.
  output logic loaded_o,  // A word with unsent bits is held.
  output logic started_o,  // Shifting of the held word has begun.
  output logic done_o  // One-cycle strobe after the last bit.
);

  if (WIDTH < 2)
  begin : g_bad_width
    $error("asop_shifter needs WIDTH of at least 2");
  end

  localparam int unsigned CW = $clog2(WIDTH);
  localparam logic [CW-1:0] LAST = CW'(WIDTH - 1);

  logic [WIDTH-1:0] sr_q;
  logic [CW-1:0] cnt_q;

  // ---------------------------------------------------------------
  // Load and shift
  // ---------------------------------------------------------------
  // A read in progress locks out new words, so a load only lands before the first shift.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sr_q <= '0;
      cnt_q <= '0;
      bit_o <= 1'b0;
      loaded_o <= 1'b0;
      started_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (load_i && !started_o)
      begin
        sr_q <= word_i;
        cnt_q <= '0;
        loaded_o <= 1'b1;
      end
      else if (shift_i && loaded_o)
      begin
        bit_o <= sr_q[WIDTH-1];
        sr_q <= {sr_q[WIDTH-2:0], 1'b0};
        started_o <= 1'b1;
        cnt_q <= cnt_q + 1'b1;
        if (cnt_q == LAST)
        begin
          loaded_o <= 1'b0;
          started_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

endmodule : asop_shifter

// >>> rtl/asop_device.sv
// Converter end: conversion timing, output coding, ready flag and serial port.
//
// What this block does
// - Mode pin high: self-clocked, drive shift clock.
// - Self-clocked shift clock divided from master clock.
// - Self-clocked, select high: data, clock floating.
// - Select low at ready fall: send word, MSB first.
// - Self-clocked: change on rise, capture next rise.
// - Ready returns high after last bit out.
// - Mode pin low: external shift clock input.
// - Conversion end loads word, drives ready low.
// - Controller waits ready fall, selects, clocks.
// - External clock: advance on rise, latch next.
// - Controller may hold select low permanently.
// - Started read is never disturbed until empty.
// - Unread word overwritten by next conversion.
// - Unread, selected: ready high before conversion end.
// - Controller holds channel until ready falls.
// - After ready falls, switch channel, then read.
// - Next start waits for read and settling; the controller waits only for idle and ready high, with no settling time.
// - Start input low begins fixed-length conversion.
// - Single conversion: start returns high early enough.
// - Polarity high: clamped two's complement codes.
// - Polarity low: clamped offset binary codes.
`timescale 1ns/1ps
module asop_device #(
  parameter int unsigned SELF_HALF = asop_pkg::SELF_HALF_CYC
) (
  input wire logic clock_i,  // Master clock.
  input wire logic sys_rst_i,  // Asynchronous reset, active high.
  input wire logic signed [17:0] analog_level_i,  // Input level in LSB, mid-scale zero.
  output logic conversion_start_n_busy_o,  // Conversion in progress.
  asop_if.dev lnk  // Pins toward the controller.
);

  if (SELF_HALF < 2)
  begin : g_bad_half
    $error("asop_device needs SELF_HALF of at least 2");
  end

  localparam logic [6:0] CONVERSION_START_N_LAST = 7'(asop_pkg::CONVERSION_START_N_CYCLES - 1);
  localparam logic [6:0] CONVERSION_START_N_EARLY = 7'(asop_pkg::CONVERSION_START_N_CYCLES - 1 - asop_pkg::RDY_EARLY_CYC);
  localparam logic [4:0] RISES_LAST = 5'(asop_pkg::SCLK_RISES);
  localparam logic [7:0] HALF_LAST = 8'(SELF_HALF - 1);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic sclk_prev_q;
  logic sclk_s;
  logic cs_n_s;
  logic conversion_start_n_n_s;
  logic self_s;
  logic bipolar_s;

  // Every pin passes two flip-flops; the first stage feeds only the second.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      meta_q <= asop_pkg::DEV_SYNC_RST;
      sync_q <= asop_pkg::DEV_SYNC_RST;
      sclk_prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= {lnk.sclk, lnk.cs_n, lnk.conversion_start_n_n, lnk.mode, lnk.pol};
      sync_q <= meta_q;
      sclk_prev_q <= sync_q[4];
    end
  end

  assign sclk_s = sync_q[4];
  assign cs_n_s = sync_q[3];
  assign conversion_start_n_n_s = sync_q[2];
  assign self_s = sync_q[1];
  assign bipolar_s = sync_q[0];

  // ---------------------------------------------------------------
  // Conversion timing
  // ---------------------------------------------------------------
  logic [6:0] conversion_start_n_cnt_q;
  logic conversion_start_n_end;
  logic conversion_start_n_early;

  // Holding the start input low restarts at once, giving back-to-back conversions.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      conversion_start_n_busy_o <= 1'b0;
      conversion_start_n_cnt_q <= 7'h00;
    end
    else if (!conversion_start_n_busy_o)
    begin
      conversion_start_n_cnt_q <= 7'h00;
      conversion_start_n_busy_o <= !conversion_start_n_n_s;
    end
    else if (conversion_start_n_cnt_q == CONVERSION_START_N_LAST)
    begin
      conversion_start_n_cnt_q <= 7'h00;
      conversion_start_n_busy_o <= !conversion_start_n_n_s;
    end
    else
    begin
      conversion_start_n_cnt_q <= conversion_start_n_cnt_q + 7'h01;
    end
  end

  assign conversion_start_n_end = conversion_start_n_busy_o && (conversion_start_n_cnt_q == CONVERSION_START_N_LAST);
  assign conversion_start_n_early = conversion_start_n_busy_o && (conversion_start_n_cnt_q == CONVERSION_START_N_EARLY);

  // ---------------------------------------------------------------
  // Shift register and ready flag
  // ---------------------------------------------------------------
  logic [15:0] code;
  logic load;
  logic shift;
  logic shift_self_q;
  logic shift_ext;
  logic loaded;
  logic started;
  logic done;
  logic rdy_n_q;

  assign code = asop_pkg::asop_encode(analog_level_i, bipolar_s);
  // A word that finishes while a read is under way is dropped rather than queued.
  assign load = conversion_start_n_end && !started;
  // External edges count only while selected; a 17th edge finds the word empty.
  assign shift_ext = !self_s && !cs_n_s && sclk_s && !sclk_prev_q;
  assign shift = self_s ? shift_self_q : shift_ext;

  asop_shifter #(
    .WIDTH(asop_pkg::WORD_BITS)
  ) u_shifter (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .load_i(load),
    .word_i(code),
    .shift_i(shift),
    .bit_o(lnk.serial_data_output),
    .loaded_o(loaded),
    .started_o(started),
    .done_o(done)
  );

  // A new load outranks a release in the same cycle, so fresh data is never missed.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rdy_n_q <= 1'b1;
    else if (load)
      rdy_n_q <= 1'b0;
    else if (done)
      rdy_n_q <= 1'b1;
    else if (conversion_start_n_early && loaded && !started && !cs_n_s)
      rdy_n_q <= 1'b1;
  end

  assign lnk.rdy_n = rdy_n_q;

  // ---------------------------------------------------------------
  // Self-clocked shift clock
  // ---------------------------------------------------------------
  logic tx_q;
  logic sclk_q;
  logic [7:0] div_q;
  logic [4:0] rises_q;
  logic tick;

  assign tick = tx_q && (div_q == HALF_LAST);

  // One extra rising edge follows the last bit so the receiver can capture it.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tx_q <= 1'b0;
      sclk_q <= 1'b0;
      div_q <= 8'h00;
      rises_q <= 5'h00;
    end
    else if (load && self_s && !cs_n_s && !tx_q)
    begin
      tx_q <= 1'b1;
      sclk_q <= 1'b0;
      div_q <= 8'h00;
      rises_q <= 5'h00;
    end
    else if (tick)
    begin
      div_q <= 8'h00;
      sclk_q <= !sclk_q;
      if (!sclk_q)
        rises_q <= rises_q + 5'h01;
      else if (rises_q == RISES_LAST)
        tx_q <= 1'b0;
    end
    else if (tx_q)
    begin
      div_q <= div_q + 8'h01;
    end
  end

  // The bit changes one master cycle after the rising edge, never on the same edge.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      shift_self_q <= 1'b0;
    else
      shift_self_q <= tick && !sclk_q;
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  logic sdo_oe_q;
  logic sclk_oe_q;

  // Deselecting floats both pins within three master cycles.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sdo_oe_q <= 1'b0;
      sclk_oe_q <= 1'b0;
    end
    else
    begin
      sdo_oe_q <= !cs_n_s;
      sclk_oe_q <= self_s && !cs_n_s;
    end
  end

  assign lnk.sdo_oe = sdo_oe_q;
  assign lnk.sclk_dev = sclk_q;
  assign lnk.sclk_dev_oe = sclk_oe_q;

endmodule : asop_device

// >>> tb/asop_monitor.sv
// Checker of the pin relations between the converter end and the controller end.
`timescale 1ns/1ps
module asop_monitor #(
  parameter int unsigned SELF_HALF = 2
) (
  input wire logic clock_i,  // Master clock.
  input wire logic sys_rst_i,  // Reset, active high.
  input wire logic sclk,  // Resolved shift clock.
  input wire logic sclk_dev_oe,  // Converter drives the shift clock.
  input wire logic serial_data_output,  // Data bit from the converter.
  input wire logic sdo_oe,  // Converter drives the data pin.
  input wire logic cs_n,  // Select, active low.
  input wire logic rdy_n,  // Ready flag, active low.
  input wire logic conversion_start_n_n,  // Conversion start, active low.
  input wire logic mode  // Port mode, high for self-clocked.
);
  logic sclk_q;
  logic rdy_q;
  logic [4:0] rise_q;
  logic [7:0] hi_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  // ---------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------
  // Previous pin levels, for edge detection in the counters.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sclk_q <= 1'b0;
      rdy_q <= 1'b1;
    end
    else
    begin
      sclk_q <= sclk;
      rdy_q <= rdy_n;
    end
  end

  // Shift clock rises since the last word was announced; saturates to stay meaningful.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rise_q <= 5'h00;
    else if (rdy_q && !rdy_n)
      rise_q <= 5'h00;
    else if (sclk && !sclk_q && rise_q != 5'h1F)
      rise_q <= rise_q + 5'h01;
  end

  // Length of the current high phase of the shift clock.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      hi_q <= 8'h00;
    else if (sclk)
      hi_q <= hi_q + 8'h01;
    else
      hi_q <= 8'h00;
  end

  a_idle_floats: assert property (cs_n [*5] |-> !sdo_oe && !sclk_dev_oe)
    else $error("pins driven while deselected");
  a_self_drives_clk: assert property ((mode && !cs_n) [*5] |-> sclk_dev_oe)
    else $error("shift clock not driven in self-clocked mode");
  a_ext_clk_input: assert property ((!mode) [*5] |-> !sclk_dev_oe)
    else $error("shift clock driven in external-clock mode");
  a_self_half_period: assert property (sclk_dev_oe && sclk_q && !sclk |-> hi_q == 8'(SELF_HALF))
    else $error("self-clocked high phase has wrong length");
  a_conversion_start_n_time: assert property ($fell(conversion_start_n_n) && rdy_n |-> ##80 rdy_n ##[1:5] !rdy_n)
    else $error("ready did not fall after the conversion time");
  a_self_ready_len: assert property ($rose(rdy_n) && mode |-> rise_q == 5'h10)
    else $error("ready returned high before sixteen bits");
  a_read_undisturbed: assert property (!cs_n && rise_q inside {[5'h01:5'h0F]} |-> !rdy_n)
    else $error("started read disturbed");
  a_word_rises: assert property (rise_q <= 5'h11)
    else $error("too many shift clock rises for one word");
  a_self_data_edge: assert property (mode && sdo_oe && $past(sdo_oe) && $changed(serial_data_output) |-> $past(sclk))
    else $error("data changed away from a rising shift clock");

  c_self_word: cover property ($fell(rdy_n) && mode && !cs_n);
  c_ext_word: cover property ($rose(rdy_n) && !mode);
  c_conversion_start_n_start: cover property ($fell(conversion_start_n_n));
endmodule : asop_monitor

// >>> tb/adc_serial_output_port_tb.sv
// Bench joining the converter end and the controller end through the pin carrier.
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin checks_done++; if ((sn) !== (ex)) begin num_errors++; \
  $display("BAD %s exp %h got %h", nm, ex, sn); end end
module adc_serial_output_port_tb;
  logic clock_i, sys_rst_i, self_mode, polarity, conversion_start_n_req, conversion_start_n_cont, cs_hold;
  logic signed [17:0] level;
  logic busy, word_valid, reading;
  logic [15:0] word;
  int num_errors = 0;
  int checks_done = 0;
  int lv[5] = '{32767, -32768, 40000, -40000, 4660};

  asop_if lnk_if();
  asop_device #(.SELF_HALF(2)) asop_device_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .analog_level_i(level), .conversion_start_n_busy_o(busy), .lnk(lnk_if));
  asop_host #(.EXT_HALF(8)) asop_host_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .self_mode_i(self_mode), .polarity_i(polarity), .conversion_start_n_req_i(conversion_start_n_req),
    .conversion_start_n_cont_i(conversion_start_n_cont), .cs_hold_i(cs_hold), .word_o(word), .word_valid_o(word_valid),
    .reading_o(reading), .lnk(lnk_if));
  asop_monitor #(.SELF_HALF(2)) asop_monitor_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .sclk(lnk_if.sclk), .sclk_dev_oe(lnk_if.sclk_dev_oe), .serial_data_output(lnk_if.serial_data_output),
    .sdo_oe(lnk_if.sdo_oe), .cs_n(lnk_if.cs_n), .rdy_n(lnk_if.rdy_n),
    .conversion_start_n_n(lnk_if.conversion_start_n_n), .mode(lnk_if.mode));

  // ---------------------------------------------------------------
  // Clock, helpers and scenarios
  // ---------------------------------------------------------------
  // Master clock shared by both ends, so read timing stays deterministic.
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : step

  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic wait_valid();
    int n;
    n = 0;
    while (word_valid !== 1'b1 && n < 800)
    begin
      step(1);
      n++;
    end
    `CHK("word_valid", 1'b1, word_valid)
  endtask : wait_valid

  // One single conversion and read; the expected code is clamped, then recoded.
  task automatic do_read(input logic self, input logic bip, input int lvl);
    logic [15:0] exp;
    exp = lvl > 32767 ? 16'h7FFF : (lvl < -32768 ? 16'h8000 : 16'(lvl));
    exp = bip ? exp : {~exp[15], exp[14:0]};
    self_mode = self;
    cs_hold = self;
    polarity = bip;
    level = 18'(lvl);
    step(8);
    conversion_start_n_req = 1'b1;
    step(1);
    conversion_start_n_req = 1'b0;
    step(10);
    `CHK("conversion_start_n_busy", 1'b1, busy)
    wait_valid();
    `CHK("word", exp, word)
    step(6);
    `CHK("rdy_n", 1'b1, lnk_if.rdy_n)
    `CHK("cs_n", ~self, lnk_if.cs_n)
  endtask : do_read

  // Boundary and clamped levels in both codings and both port modes.
  task automatic scen_codes();
    for (int s = 1; s >= 0; s--)
      for (int p = 0; p < 2; p++)
        for (int i = 0; i < 5; i++)
          do_read(s[0], p[0], lv[i]);
  endtask : scen_codes

  // Back-to-back conversions with select held low; level changes between words.
  task automatic scen_continuous();
    int n;
    self_mode = 1'b1;
    cs_hold = 1'b1;
    polarity = 1'b1;
    level = 18'h00064;
    step(8);
    conversion_start_n_cont = 1'b1;
    wait_valid();
    level = 18'h000C8;
    step(1);
    n = 1;
    while (word_valid !== 1'b1 && n < 200)
    begin
      step(1);
      n++;
    end
    `CHK("period", 80, n)
    `CHK("word", 16'h00C8, word)
    conversion_start_n_cont = 1'b0;
    step(200);
  endtask : scen_continuous

  // External clock, select held low, conversions running: words done mid-read are dropped.
  task automatic scen_ext_hold();
    self_mode = 1'b0;
    cs_hold = 1'b1;
    polarity = 1'b1;
    level = 18'h00123;
    step(8);
    conversion_start_n_cont = 1'b1;
    step(100);
    level = 18'h00456;
    `CHK("cs_n", 1'b0, lnk_if.cs_n)
    wait_valid();
    `CHK("word", 16'h0123, word)
    conversion_start_n_cont = 1'b0;
    step(700);
    `CHK("rdy_n", 1'b1, lnk_if.rdy_n)
  endtask : scen_ext_hold

  // Reset in the middle of an external-clock read, then a clean read.
  task automatic scen_mid_reset();
    int n;
    self_mode = 1'b0;
    cs_hold = 1'b0;
    step(8);
    conversion_start_n_req = 1'b1;
    step(1);
    conversion_start_n_req = 1'b0;
    n = 0;
    while (reading !== 1'b1 && n < 200)
    begin
      step(1);
      n++;
    end
    `CHK("reading", 1'b1, reading)
    step(40);
    sys_rst_i = 1'b1;
    step(3);
    `CHK("cs_n", 1'b1, lnk_if.cs_n)
    `CHK("rdy_n", 1'b1, lnk_if.rdy_n)
    `CHK("sdo_oe", 1'b0, lnk_if.sdo_oe)
    sys_rst_i = 1'b0;
    do_read(1'b0, 1'b1, -2);
  endtask : scen_mid_reset

  // Watchdog sized well beyond the roughly eight thousand cycles the scenarios need.
  initial
  begin
    #2000000;
    num_errors++;
    give_verdict();
  end

  // Main sequence.
  initial
  begin
    sys_rst_i = 1'b1;
    self_mode = 1'b0;
    polarity = 1'b1;
    conversion_start_n_req = 1'b0;
    conversion_start_n_cont = 1'b0;
    cs_hold = 1'b0;
    level = 18'h00000;
    step(12);
    sys_rst_i = 1'b0;
    scen_codes();
    scen_continuous();
    scen_ext_hold();
    scen_mid_reset();
    give_verdict();
  end
endmodule : adc_serial_output_port_tb
